// ==== hw/amst_pkg.sv ====
// amst_pkg: constants and carrier types of the asynchronous memory strobe sequencer
// assumes a 32-bit APB slave port and a word-addressed external async memory port
package amst_pkg;
  localparam int unsigned SPACES      = 4;
  localparam int unsigned SPACE_W     = 2;
  localparam int unsigned ADDR_W      = 20;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned LANES       = 4;
  localparam int unsigned CNT_W       = 6;

  // register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_ADDR     = 8'h04;
  localparam logic [7:0] OFS_WDATA    = 8'h08;
  localparam logic [7:0] OFS_LANES    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_RDATA    = 8'h14;
  localparam logic [7:0] OFS_TIMING0  = 8'h20;

  // command register fields
  localparam int unsigned CMD_SPACE_LSB = 0;
  localparam int unsigned CMD_WRITE_BIT = 4;
  // status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;

  // timing register fields
  localparam int unsigned RSETUP_LSB  = 0;
  localparam int unsigned RSTROBE_LSB = 4;
  localparam int unsigned RHOLD_LSB   = 10;
  localparam int unsigned WSETUP_LSB  = 16;
  localparam int unsigned WSTROBE_LSB = 20;
  localparam int unsigned WHOLD_LSB   = 26;
  localparam int unsigned SETUP_W     = 4;
  localparam int unsigned STROBE_W    = 6;
  localparam int unsigned HOLD_W      = 3;

  // reset values
  localparam logic [31:0] TIMING_RST  = 32'h1FFF_1FFF;
  localparam logic [3:0]  LANES_RST   = 4'hF;

  typedef enum logic [1:0] {AMST_IDLE, AMST_SETUP, AMST_STROBE, AMST_HOLD} amst_phase_e;

  // one access as handed to the link side
  typedef struct packed {
    logic [SPACE_W-1:0]  space;
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [LANES-1:0]    lanes;
    logic [SETUP_W-1:0]  setup;
    logic [STROBE_W-1:0] strobe;
    logic [HOLD_W-1:0]   hold;
  } amst_cmd_s;

  // external memory pins, active-low ones marked _n
  typedef struct packed {
    logic [SPACES-1:0] space_select_n;
    logic [LANES-1:0]  byte_lane_enable_n;
    logic [ADDR_W-1:0] ext_word_address;
    logic [DATA_W-1:0] ext_data_out;
    logic              ext_data_oe;
    logic              async_output_enable_n;
    logic              async_read_strobe_n;
    logic              async_write_strobe_n;
  } amst_pins_s;
endpackage

// ==== hw/amst_top.sv ====
// amst_top: APB-programmed sequencer for async SRAM/EPROM accesses plus clock outputs
// assumes EXT_BUS_CLOCK_IN runs free; the sequencer runs on it, registers on CLK
//
// Notes on behaviour
// - selects stay valid read-setup bus clocks before read strobe falls
// - selects stay valid read-hold bus clocks after read strobe rises
// - selects and write data valid write-setup bus clocks before write strobe falls
// - selects and write data held write-hold bus clocks after write strobe rises
// - six phase lengths come from each space's own timing register
// - phases count external bus clock periods, not CPU clocks
// - ready input is synchronised through two flops and acted on two bus clocks after it is sampled
// - selects are space select, lane enables, word address, output enable, write data
// - the three shared pins serve as output enable, read and write strobe
// - read data is captured where the read strobe rises
// - strobes change only on rising bus clock edges
// - ready is sampled on rising bus clock edges
// - bus clock output copies the bus clock input edge for edge
// - half-rate clock output toggles every CPU clock while CE is high, high and low one period
// - CPU-rate clock output follows the CPU clock, its high and low times
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module amst_top
  import amst_pkg::*;
(
  // cpu clock domain
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                CE,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // external bus clock
  input  wire logic                EXT_BUS_CLOCK_IN,
  output logic                     EXT_BUS_CLOCK_OUT,
  // derived clocks
  output logic                     CPU_RATE_CLOCK_OUT,
  output logic                     HALF_RATE_CLOCK_OUT,
  // async memory pins
  output logic [SPACES-1:0]        SPACE_SELECT_N,
  output logic [LANES-1:0]         BYTE_LANE_ENABLE_N,
  output logic [ADDR_W-1:0]        EXT_WORD_ADDRESS,
  input  wire logic [DATA_W-1:0]   EXT_DATA_IN,
  output logic [DATA_W-1:0]        EXT_DATA_OUT,
  output logic                     EXT_DATA_OE,
  output logic                     ASYNC_OUTPUT_ENABLE_N,
  output logic                     ASYNC_READ_STROBE_N,
  output logic                     ASYNC_WRITE_STROBE_N,
  input  wire logic                ASYNC_READY_IN
);

  // ---------------- cpu domain ----------------
  typedef struct packed {
    logic [SPACES-1:0][31:0] timing;
    logic [SPACE_W-1:0]      space;
    logic                    write;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       wdata;
    logic [LANES-1:0]        lanes;
    amst_cmd_s               cmd;
    logic                    busy;
    logic                    req_tgl;
    logic [2:0]              done_sync;
    logic [DATA_W-1:0]       rdata;
    logic                    half_clk;
  } amst_cpu_s;

  // ---------------- link domain ----------------
  typedef struct packed {
    logic [1:0]          ce_sync;
    logic [2:0]          req_sync;
    logic [1:0]          rdy_sync;
    amst_phase_e         phase;
    logic [CNT_W-1:0]    count;
    logic                write;
    logic [STROBE_W-1:0] strobe;
    logic [HOLD_W-1:0]   hold;
    amst_pins_s          pins;
    logic [DATA_W-1:0]   capture;
    logic                done_tgl;
  } amst_link_s;

  amst_cpu_s  cpu_reg;
  amst_cpu_s  cpu_next;
  amst_link_s link_reg;
  amst_link_s link_next;
  logic [1:0] link_rst_sync;
  logic       link_rst;

  // a zero length still takes one bus clock
  function automatic logic [CNT_W-1:0] phase_load(input logic [CNT_W-1:0] len);
    phase_load = (len == '0) ? '0 : CNT_W'(len - 1'b1);
  endfunction

  function automatic amst_pins_s pins_idle();
    amst_pins_s p;
    p = '0;
    p.space_select_n        = '1;
    p.byte_lane_enable_n    = '1;
    p.async_output_enable_n = 1'b1;
    p.async_read_strobe_n   = 1'b1;
    p.async_write_strobe_n  = 1'b1;
    return p;
  endfunction

  logic       apb_access;
  logic       apb_hit;
  logic [2:0] tslot;
  logic       done_seen;

  assign apb_access = PSEL && PENABLE;
  assign tslot      = PADDR[4:2];
  assign done_seen  = cpu_reg.done_sync[2] ^ cpu_reg.done_sync[1];

  always_comb begin
    apb_hit = 1'b1;
    PRDATA  = '0;
    case (PADDR)
      OFS_CMD:    PRDATA = 32'(cpu_reg.space) | (32'(cpu_reg.write) << CMD_WRITE_BIT);
      OFS_ADDR:   PRDATA = 32'(cpu_reg.addr);
      OFS_WDATA:  PRDATA = cpu_reg.wdata;
      OFS_LANES:  PRDATA = 32'(cpu_reg.lanes);
      OFS_STATUS: PRDATA = 32'(cpu_reg.busy) << STAT_BUSY_BIT;
      OFS_RDATA:  PRDATA = cpu_reg.rdata;
      default: begin
        if (PADDR[7:5] == OFS_TIMING0[7:5] && tslot < 3'(SPACES) && PADDR[1:0] == 2'h0) begin
          PRDATA = cpu_reg.timing[tslot[SPACE_W-1:0]];
        end else begin
          apb_hit = 1'b0;
        end
      end
    endcase
  end

  // zero-wait slave; unmapped offsets answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_access && !apb_hit;

  always_comb begin
    cpu_next           = cpu_reg;
    cpu_next.half_clk  = ~cpu_reg.half_clk;
    cpu_next.done_sync = {cpu_reg.done_sync[1:0], link_reg.done_tgl};
    if (done_seen) begin
      // link holds capture steady until the next request
      cpu_next.rdata = link_reg.capture;
      cpu_next.busy  = 1'b0;
    end
    if (apb_access && PWRITE && apb_hit) begin
      case (PADDR)
        OFS_ADDR:  cpu_next.addr  = PWDATA[ADDR_W-1:0];
        OFS_WDATA: cpu_next.wdata = PWDATA;
        OFS_LANES: cpu_next.lanes = PWDATA[LANES-1:0];
        OFS_CMD: begin
          cpu_next.space = PWDATA[CMD_SPACE_LSB +: SPACE_W];
          cpu_next.write = PWDATA[CMD_WRITE_BIT];
          // a start while busy is dropped; the snapshot must stay put during the access
          if (!cpu_reg.busy) begin
            cpu_next.cmd.space = PWDATA[CMD_SPACE_LSB +: SPACE_W];
            cpu_next.cmd.write = PWDATA[CMD_WRITE_BIT];
            cpu_next.cmd.addr  = cpu_reg.addr;
            cpu_next.cmd.wdata = cpu_reg.wdata;
            cpu_next.cmd.lanes = cpu_reg.lanes;
            if (PWDATA[CMD_WRITE_BIT]) begin
              cpu_next.cmd.setup  = cpu_reg.timing[PWDATA[CMD_SPACE_LSB +: SPACE_W]][WSETUP_LSB +: SETUP_W];
              cpu_next.cmd.strobe = cpu_reg.timing[PWDATA[CMD_SPACE_LSB +: SPACE_W]][WSTROBE_LSB +: STROBE_W];
              cpu_next.cmd.hold   = cpu_reg.timing[PWDATA[CMD_SPACE_LSB +: SPACE_W]][WHOLD_LSB +: HOLD_W];
            end else begin
              cpu_next.cmd.setup  = cpu_reg.timing[PWDATA[CMD_SPACE_LSB +: SPACE_W]][RSETUP_LSB +: SETUP_W];
              cpu_next.cmd.strobe = cpu_reg.timing[PWDATA[CMD_SPACE_LSB +: SPACE_W]][RSTROBE_LSB +: STROBE_W];
              cpu_next.cmd.hold   = cpu_reg.timing[PWDATA[CMD_SPACE_LSB +: SPACE_W]][RHOLD_LSB +: HOLD_W];
            end
            cpu_next.busy    = 1'b1;
            cpu_next.req_tgl = ~cpu_reg.req_tgl;
          end
        end
        default: begin
          if (PADDR[7:5] == OFS_TIMING0[7:5]) begin
            cpu_next.timing[tslot[SPACE_W-1:0]] = PWDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cpu_reg        <= '0;
      cpu_reg.timing <= {SPACES{TIMING_RST}};
      cpu_reg.lanes  <= LANES_RST;
    end else if (CE) begin
      cpu_reg <= cpu_next;
    end
  end

  // reset brought into the link domain, released two bus clocks late
  always_ff @(posedge EXT_BUS_CLOCK_IN) begin
    link_rst_sync <= {link_rst_sync[0], RST};
  end
  assign link_rst = link_rst_sync[1];

  logic link_run;
  logic req_seen;
  assign link_run = link_reg.ce_sync[1];
  assign req_seen = link_reg.req_sync[2] ^ link_reg.req_sync[1];

  always_comb begin
    link_next          = link_reg;
    link_next.ce_sync  = {link_reg.ce_sync[0], CE};
    link_next.rdy_sync = {link_reg.rdy_sync[0], ASYNC_READY_IN};
    if (link_run) begin
      // request sync holds while frozen, else a toggle landing then would be lost
      link_next.req_sync = {link_reg.req_sync[1:0], cpu_reg.req_tgl};
      case (link_reg.phase)
        AMST_IDLE: begin
          if (req_seen) begin
            // command words were stable two bus clocks before the toggle arrived
            link_next.write  = cpu_reg.cmd.write;
            link_next.strobe = cpu_reg.cmd.strobe;
            link_next.hold   = cpu_reg.cmd.hold;
            link_next.pins.space_select_n                       = '1;
            link_next.pins.space_select_n[cpu_reg.cmd.space]    = 1'b0;
            link_next.pins.byte_lane_enable_n                   = ~cpu_reg.cmd.lanes;
            link_next.pins.ext_word_address                     = cpu_reg.cmd.addr;
            link_next.pins.ext_data_out                         = cpu_reg.cmd.wdata;
            link_next.pins.ext_data_oe                          = cpu_reg.cmd.write;
            link_next.pins.async_output_enable_n                = cpu_reg.cmd.write;
            link_next.count = phase_load(CNT_W'(cpu_reg.cmd.setup));
            link_next.phase = AMST_SETUP;
          end
        end
        AMST_SETUP: begin
          if (link_reg.count == '0) begin
            // strobe falls only after the full setup count
            link_next.pins.async_read_strobe_n  = link_reg.write;
            link_next.pins.async_write_strobe_n = ~link_reg.write;
            link_next.count = phase_load(CNT_W'(link_reg.strobe));
            link_next.phase = AMST_STROBE;
          end else begin
            link_next.count = CNT_W'(link_reg.count - 1'b1);
          end
        end
        AMST_STROBE: begin
          if (link_reg.count != '0) begin
            link_next.count = CNT_W'(link_reg.count - 1'b1);
          end else if (link_reg.rdy_sync[1]) begin
            link_next.pins.async_read_strobe_n  = 1'b1;
            link_next.pins.async_write_strobe_n = 1'b1;
            if (!link_reg.write) begin
              link_next.capture = EXT_DATA_IN;
            end
            link_next.count = phase_load(CNT_W'(link_reg.hold));
            link_next.phase = AMST_HOLD;
          end
        end
        AMST_HOLD: begin
          if (link_reg.count == '0) begin
            // selects released only after the full hold count
            link_next.pins     = pins_idle();
            link_next.done_tgl = ~link_reg.done_tgl;
            link_next.phase    = AMST_IDLE;
          end else begin
            link_next.count = CNT_W'(link_reg.count - 1'b1);
          end
        end
        default: begin
          link_next.pins  = pins_idle();
          link_next.phase = AMST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge EXT_BUS_CLOCK_IN) begin
    if (link_rst) begin
      link_reg      <= '0;
      link_reg.pins <= pins_idle();
    end else begin
      link_reg <= link_next;
    end
  end

  // pins straight from link flops, changing only at bus clock rising edges
  assign SPACE_SELECT_N        = link_reg.pins.space_select_n;
  assign BYTE_LANE_ENABLE_N    = link_reg.pins.byte_lane_enable_n;
  assign EXT_WORD_ADDRESS      = link_reg.pins.ext_word_address;
  assign EXT_DATA_OUT          = link_reg.pins.ext_data_out;
  assign EXT_DATA_OE           = link_reg.pins.ext_data_oe;
  assign ASYNC_OUTPUT_ENABLE_N = link_reg.pins.async_output_enable_n;
  assign ASYNC_READ_STROBE_N   = link_reg.pins.async_read_strobe_n;
  assign ASYNC_WRITE_STROBE_N  = link_reg.pins.async_write_strobe_n;

  // clock outputs: pass-through keeps the input high and low times
  assign EXT_BUS_CLOCK_OUT   = EXT_BUS_CLOCK_IN;
  assign CPU_RATE_CLOCK_OUT  = CLK;
  assign HALF_RATE_CLOCK_OUT = cpu_reg.half_clk;

endmodule

// ==== sim/amst_top_asserts.sv ====
// amst_top_asserts: pin timing checks of the async strobe sequencer
// assumes binding to amst_top; memory pins are checked on the bus clock
`timescale 1ns/1ps
module amst_top_asserts
  import amst_pkg::*;
(
  // clocks and reset
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              CE,
  input wire logic              EXT_BUS_CLOCK_IN,
  input wire logic              EXT_BUS_CLOCK_OUT,
  input wire logic              HALF_RATE_CLOCK_OUT,
  // memory pins
  input wire logic [SPACES-1:0] SPACE_SELECT_N,
  input wire logic [LANES-1:0]  BYTE_LANE_ENABLE_N,
  input wire logic [ADDR_W-1:0] EXT_WORD_ADDRESS,
  input wire logic [DATA_W-1:0] EXT_DATA_OUT,
  input wire logic              EXT_DATA_OE,
  input wire logic              ASYNC_OUTPUT_ENABLE_N,
  input wire logic              ASYNC_READ_STROBE_N,
  input wire logic              ASYNC_WRITE_STROBE_N,
  input wire logic              ASYNC_READY_IN
);
  logic sel;
  logic rd;
  logic wr;
  assign sel = ~&SPACE_SELECT_N;
  assign rd  = ~ASYNC_READ_STROBE_N;
  assign wr  = ~ASYNC_WRITE_STROBE_N;
  strobe_excl_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST) !(rd && wr))
    else $error("both strobes low");
  read_sel_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    rd |-> sel && !ASYNC_OUTPUT_ENABLE_N && !EXT_DATA_OE) else $error("read strobe without selects");
  read_setup_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    $rose(rd) |-> $past(sel) && $stable(SPACE_SELECT_N) && $stable(EXT_WORD_ADDRESS)) else $error("read setup");
  read_hold_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    $fell(rd) |-> sel && !ASYNC_OUTPUT_ENABLE_N && $stable(EXT_WORD_ADDRESS)) else $error("read hold");
  write_setup_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    $rose(wr) |-> $past(sel) && $past(EXT_DATA_OE) && $stable(EXT_DATA_OUT)) else $error("write setup");
  write_hold_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    $fell(wr) |-> sel && EXT_DATA_OE && $stable(EXT_DATA_OUT) && ASYNC_OUTPUT_ENABLE_N) else $error("write hold");
  sel_stable_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    sel && $past(sel) |-> $stable(SPACE_SELECT_N) && $stable(BYTE_LANE_ENABLE_N) && $stable(EXT_WORD_ADDRESS))
    else $error("selects moved in access");
  ready_stretch_a: assert property (@(posedge EXT_BUS_CLOCK_IN) disable iff (RST)
    $fell(rd) |-> $past(ASYNC_READY_IN, 1) || $past(ASYNC_READY_IN, 2) || $past(ASYNC_READY_IN, 3)
    || $past(ASYNC_READY_IN, 4)) else $error("strobe ended while not ready");
  clock_copy_a: assert property (@(posedge CLK) disable iff (RST) EXT_BUS_CLOCK_OUT == EXT_BUS_CLOCK_IN)
    else $error("bus clock output differs");
  half_toggle_a: assert property (@(posedge CLK) disable iff (RST)
    CE && !RST |=> HALF_RATE_CLOCK_OUT != $past(HALF_RATE_CLOCK_OUT)) else $error("half clock missed toggle");
  half_freeze_a: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(HALF_RATE_CLOCK_OUT)) else $error("half clock ran frozen");
  cov_read: cover property (@(posedge EXT_BUS_CLOCK_IN) $fell(rd));
  cov_write: cover property (@(posedge EXT_BUS_CLOCK_IN) $fell(wr));
  cov_stall: cover property (@(posedge EXT_BUS_CLOCK_IN) rd && !ASYNC_READY_IN);
endmodule

bind amst_top amst_top_asserts u_amst_top_asserts (.CLK(CLK), .RST(RST), .CE(CE),
  .EXT_BUS_CLOCK_IN(EXT_BUS_CLOCK_IN), .EXT_BUS_CLOCK_OUT(EXT_BUS_CLOCK_OUT),
  .HALF_RATE_CLOCK_OUT(HALF_RATE_CLOCK_OUT), .SPACE_SELECT_N(SPACE_SELECT_N),
  .BYTE_LANE_ENABLE_N(BYTE_LANE_ENABLE_N), .EXT_WORD_ADDRESS(EXT_WORD_ADDRESS), .EXT_DATA_OUT(EXT_DATA_OUT),
  .EXT_DATA_OE(EXT_DATA_OE), .ASYNC_OUTPUT_ENABLE_N(ASYNC_OUTPUT_ENABLE_N),
  .ASYNC_READ_STROBE_N(ASYNC_READ_STROBE_N), .ASYNC_WRITE_STROBE_N(ASYNC_WRITE_STROBE_N),
  .ASYNC_READY_IN(ASYNC_READY_IN));

// ==== sim/amst_mem_model.sv ====
// amst_mem_model: async sram of 16 words on the memory pins
// assumes selects settle on the bus clock; bench sets the ready stall length
`timescale 1ns/1ps
module amst_mem_model
  import amst_pkg::*;
(
  // pins from the sequencer, stall length from the bench
  input  wire logic              bclk,
  input  wire logic [SPACES-1:0] sel_n,
  input  wire logic [LANES-1:0]  lane_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              oe_n,
  input  wire logic              wr_n,
  input  wire logic [3:0]        stall,
  // answers
  output logic      [DATA_W-1:0] rdata,
  output logic                   ready
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last;
  logic [3:0]        cnt;
  logic              drive;
  assign drive = !(&sel_n) && !oe_n;
  // undriven bus shows no stale word, so a late capture is caught
  assign rdata = drive ? mem[addr[3:0]] : ~last;
  assign ready = (cnt == 4'h0);
  always @(posedge bclk) begin
    if (drive)
      last <= mem[addr[3:0]];
    if (&sel_n)
      cnt <= stall;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
  always @(posedge wr_n)
    for (int i = 0; i < LANES; i++)
      if (lane_n[i] === 1'b0)
        mem[addr[3:0]][8*i +: 8] <= wdata[8*i +: 8];
endmodule

// ==== sim/amst_top_tb_top.sv ====
// amst_top_tb_top: APB-driven tests of phase counts, per-space timing, ready and clocks
// assumes amst_mem_model on the memory pins and the bound pin checker
`timescale 1ns/1ps
module amst_top_tb_top
  import amst_pkg::*;
;
  logic clk, rst, ce, psel, penable, pwrite, bclk, oe, doe, rd_n, wr_n, oe_n, rdy, eco, cro, hro, pready, perr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, dout, din, rd, cap, cap_d;
  logic [3:0]  sel_n, lane_n, stall;
  logic [19:0] wa;
  logic [7:0]  n_su, n_st, n_ho;
  logic        act;
  int          n_errors, num_checks;
  amst_top u_amst_top (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .EXT_BUS_CLOCK_IN(bclk),
    .EXT_BUS_CLOCK_OUT(eco), .CPU_RATE_CLOCK_OUT(cro), .HALF_RATE_CLOCK_OUT(hro), .SPACE_SELECT_N(sel_n),
    .BYTE_LANE_ENABLE_N(lane_n), .EXT_WORD_ADDRESS(wa), .EXT_DATA_IN(din), .EXT_DATA_OUT(dout),
    .EXT_DATA_OE(doe), .ASYNC_OUTPUT_ENABLE_N(oe_n), .ASYNC_READ_STROBE_N(rd_n),
    .ASYNC_WRITE_STROBE_N(wr_n), .ASYNC_READY_IN(rdy));
  amst_mem_model u_amst_mem_model (.bclk(eco), .sel_n(sel_n), .lane_n(lane_n), .addr(wa), .wdata(dout),
    .oe_n(oe_n), .wr_n(wr_n), .stall(stall), .rdata(din), .ready(rdy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // bus clock offset so its edges never meet the cpu clock edges
  initial begin
    bclk = 1'b0;
    #1.3;
    forever #6 bclk = ~bclk;
  end
  always @(posedge eco) begin
    if (&sel_n)
      act = 1'b0;
    else begin
      if (!act) begin
        act = 1'b1;
        {n_su, n_st, n_ho} = 24'h0;
      end
      if (!rd_n || !wr_n) begin
        n_st++;
        cap = {4'h0, sel_n, lane_n, wa};
        cap_d = dout;
      end else if (n_st == 8'h0)
        n_su++;
      else
        n_ho++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic acc(input int sp, input logic w, input logic [19:0] a, input logic [31:0] d, input logic [3:0] ln);
    int n;
    apb(1'b1, OFS_ADDR, {12'h0, a});
    apb(1'b1, OFS_WDATA, d);
    apb(1'b1, OFS_LANES, {28'h0, ln});
    apb(1'b1, OFS_CMD, {27'h0, w, 2'b00, 2'(sp)});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 300);
    if (n >= 300)
      chk(32'h1, 32'h0);
    chk(cap, {4'h0, ~(4'h1 << sp), ~ln, a});
  endtask
  task automatic phases(input int s, input int t, input int h);
    chk({8'h0, n_su, n_st, n_ho}, {8'h0, 8'(s), 8'(t), 8'(h)});
  endtask
  function automatic logic [31:0] tw(input int rs, input int rt, input int rh, input int ws, input int wt, input int wh);
    return 32'(rs) << RSETUP_LSB | 32'(rt) << RSTROBE_LSB | 32'(rh) << RHOLD_LSB
      | 32'(ws) << WSETUP_LSB | 32'(wt) << WSTROBE_LSB | 32'(wh) << WHOLD_LSB;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst, ce, psel, penable, pwrite, paddr, pwdata, stall} = {1'b1, 1'b1, 3'b0, 8'h0, 32'h0, 4'h0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < SPACES; i++) begin
      apb(1'b0, OFS_TIMING0 + 8'(4 * i), 32'h0);
      chk(rd, TIMING_RST);
    end
    apb(1'b0, OFS_LANES, 32'h0);
    chk(rd, {28'h0, LANES_RST});
    apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1);
    $display("register test done");
    for (int i = 0; i < SPACES; i++) begin
      apb(1'b1, OFS_TIMING0 + 8'(4 * i), tw(i + 1, i + 3, i + 1, i + 2, i + 2, i + 1));
      acc(i, 1'b1, 20'(32'hA5000 + i), 32'h1234_5670 + 32'(i), 4'hF);
      phases(i + 2, i + 2, i + 1);
      chk(cap_d, 32'h1234_5670 + 32'(i));
      acc(i, 1'b0, 20'(32'hA5000 + i), 32'h0, 4'hF);
      phases(i + 1, i + 3, i + 1);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'h1234_5670 + 32'(i));
    end
    $display("space timing test done");
    acc(0, 1'b1, 20'hA5000, 32'hFFFF_FFFF, 4'h5);
    acc(0, 1'b0, 20'hA5000, 32'h0, 4'hF);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h12FF_56FF);
    $display("lane test done");
    stall <= 4'h6;
    apb(1'b1, OFS_TIMING0 + 8'h4, tw(3, 2, 1, 3, 2, 1));
    acc(1, 1'b0, 20'hA5001, 32'h0, 4'hF);
    chk({31'h0, n_st >= 8'h4 && n_st <= 8'h9}, 32'h1);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h1234_5671);
    stall <= 4'h0;
    $display("ready test done");
    @(posedge clk);
    #1 chk({31'h0, cro}, 32'h1);
    #10 chk({31'h0, cro}, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1 rd = {31'h0, hro};
    repeat (3) @(posedge clk);
    #1 chk({31'h0, hro}, rd);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1 chk({31'h0, hro}, {31'h0, ~rd[0]});
    $display("clock test done");
    tally_and_finish;
  end
  initial begin
    #1_000_000;
    n_errors++;
    tally_and_finish;
  end
endmodule
